// file: hdl/cgw_regs.svh
// register offsets, field positions, reset values and timing figures
`ifndef CGW_REGS_SVH
`define CGW_REGS_SVH
// ========================================
// register offsets (smbus command codes)
`define CGW_OFS_TIMEOUT 8'h08
`define CGW_OFS_CTRL 8'h09
`define CGW_OFS_SKEW 8'h0a
// ========================================
// watchdog_timeout_prescale fields
`define CGW_TO_HI 5
`define CGW_TO_LO 1
`define CGW_PRESC_BIT 0
`define CGW_TO_RST 5'h1f
// ========================================
// drive_reset_watchdog_ctrl fields
`define CGW_USB_DRV_BIT 7
`define CGW_PCI_CLK_DRIVE_HIGH_BIT 6
`define CGW_AGP_DRV_BIT 5
`define CGW_RST_WD_BIT 4
`define CGW_RST_FC_BIT 3
`define CGW_FLAG_BIT 2
`define CGW_RUN_BIT 1
// ========================================
// output_skew_ctrl fields
`define CGW_CPU_SKEW_HI 7
`define CGW_CPU_SKEW_LO 5
`define CGW_PCI_SKEW_HI 3
`define CGW_PCI_SKEW_LO 2
`define CGW_AGP_SKEW_HI 1
`define CGW_AGP_SKEW_LO 0
// ========================================
// timing and smbus address
`define CGW_CLK_MHZ 50
`define CGW_SHORT_TICK_MS 150
`define CGW_LONG_TICK_MS 2500
`define CGW_MS_TO_CYC(ms) ((ms) * 1000 * `CGW_CLK_MHZ)
`define CGW_RST_PULSE_CYC 8'h64
`define CGW_FS_SETTLE 2'h3
`define CGW_SMB_ADDR 7'h50
`endif

// file: hdl/cgw_pkg.sv
// types shared by the watchdog and tuning control block
package cgw_pkg;
	// ========================================
	// grouped outputs
	typedef struct packed {
		logic usb;
		logic pci;
		logic agp;
	} cgw_drive_t;

	typedef struct packed {
		logic [2:0] cpu;
		logic [1:0] pci;
		logic [1:0] agp;
	} cgw_skew_t;

	typedef struct packed {
		logic valid;
		logic [7:0] cmd;
		logic [7:0] data;
	} cgw_ext_wr_t;

	// ========================================
	// state machines
	typedef enum logic [1:0] {
		WD_OFF,
		WD_ARMED,
		WD_COUNT,
		WD_LOCKED
	} cgw_wd_state_t;

	typedef enum logic [3:0] {
		SMB_IDLE,
		SMB_ADDR,
		SMB_ADDR_ACK,
		SMB_CMD,
		SMB_CMD_ACK,
		SMB_WDATA,
		SMB_WDATA_ACK,
		SMB_RDATA,
		SMB_RDATA_ACK
	} cgw_smb_state_t;
endpackage : cgw_pkg

// file: hdl/cgw_watchdog_ctrl.sv
// smbus-reached watchdog, reset, drive strength and skew control bytes
`timescale 1ns/1ps
`include "cgw_regs.svh"

// Operation
// (R1) five-bit watchdog time-out, unit is one prescaler tick
// (R2) prescaler select: 0 gives 150 ms ticks, 1 gives 2.5 s ticks
// (R3) count reaching zero sets time-out flag, resets system if enabled
// (R4) watchdog reset enable gates expiry reset; powers up 0
// (R5) frequency-change reset enable issues reset pulse after each frequency change; the code issues none while freq_lock_o is high
// (R6) flag reads 1 after time-out, 0 otherwise; writing 0 does nothing
// (R7) writing 1 to the flag clears it
// (R8) watchdog enable at 0 stops counting and reloads time-out value
// (R9) with enable at 1, counting starts after a frequency change
// (R10) expiry raises reset, loads recovery frequency, enters locked mode
// (R11) locked mode ignores all writes that change output frequency
// (R12) writing 0 to watchdog enable unlocks frequency controls
// (R13) three drive select bits: 0 normal, 1 high drive
// (R14) three-bit cpu skew field, 000 normal, 100..111 positive steps
// (R15) two-bit pci skew field, 10 reserved
// (R16) two-bit agp skew field, four codes
// (R17) recovery source 0 uses latched straps, 1 uses programmed dividers
// (R18) watchdog decrements once per prescaler tick; fixed reset pulse width
// (R19) reserved bits read 0 and ignore writes
module cgw_watchdog_ctrl #(
	parameter int unsigned SHORT_TICK_CYC = `CGW_MS_TO_CYC(`CGW_SHORT_TICK_MS),
	parameter int unsigned LONG_TICK_CYC = `CGW_MS_TO_CYC(`CGW_LONG_TICK_MS),
	parameter logic [6:0] SMB_ADDR = `CGW_SMB_ADDR
) (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// smbus pins
	input wire logic smb_clk_i,
	input wire logic smb_data_i,
	output logic smb_data_o,
	output logic smb_data_oe_o,
	// frequency logic
	input wire logic freq_change_i,
	input wire logic recovery_source_sel_i,
	input wire logic [4:0] fs_strap_i,
	output cgw_pkg::cgw_ext_wr_t ext_wr_o,
	output logic freq_lock_o,
	output logic recovery_load_o,
	output logic recovery_from_prog_o,
	output logic [4:0] recovery_fs_o,
	// system and output tuning
	output logic sys_reset_o,
	output cgw_pkg::cgw_drive_t drive_o,
	output cgw_pkg::cgw_skew_t skew_o
);
	// ========================================
	// elaboration checks
	if (SHORT_TICK_CYC < 1 || LONG_TICK_CYC < 1) begin : g_bad_tick
		$error("tick counts must be at least one cycle");
	end

	// ========================================
	// pin synchronisers
	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	logic [4:0] fs_meta_q;
	logic [4:0] fs_sync_q;
	logic scl_prev_q;
	logic sda_prev_q;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			fs_meta_q <= 5'h00;
			fs_sync_q <= 5'h00;
			scl_prev_q <= 1'h1;
			sda_prev_q <= 1'h1;
		end else begin
			scl_sync_q <= {scl_sync_q[0], smb_clk_i};
			sda_sync_q <= {sda_sync_q[0], smb_data_i};
			fs_meta_q <= fs_strap_i;
			fs_sync_q <= fs_meta_q;
			scl_prev_q <= scl_sync_q[1];
			sda_prev_q <= sda_sync_q[1];
		end
	end

	logic scl;
	logic sda;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	assign scl = scl_sync_q[1];
	assign sda = sda_sync_q[1];
	assign scl_rise = scl & ~scl_prev_q;
	assign scl_fall = ~scl & scl_prev_q;
	assign bus_start = scl & scl_prev_q & sda_prev_q & ~sda;
	assign bus_stop = scl & scl_prev_q & ~sda_prev_q & sda;

	// ========================================
	// control registers
	logic [4:0] timeout_q;
	logic presc_q;
	logic rst_wdog_run_q;
	logic rst_fc_en_q;
	logic flag_q;
	logic run_q;
	logic wr_stb;
	logic [7:0] cmd_q;
	logic [7:0] shift_q;
	logic expire;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			timeout_q <= `CGW_TO_RST;
			presc_q <= 1'h0;
			drive_o <= '0;
			rst_wdog_run_q <= 1'h0; // R4
			rst_fc_en_q <= 1'h0;
			run_q <= 1'h0;
			skew_o <= '0;
		end else if (wr_stb) begin
			unique case (cmd_q)
				`CGW_OFS_TIMEOUT: begin
					timeout_q <= shift_q[`CGW_TO_HI:`CGW_TO_LO]; // R1
					presc_q <= shift_q[`CGW_PRESC_BIT]; // R2
				end
				`CGW_OFS_CTRL: begin
					drive_o.usb <= shift_q[`CGW_USB_DRV_BIT]; // R13
					drive_o.pci <= shift_q[`CGW_PCI_CLK_DRIVE_HIGH_BIT]; // R13
					drive_o.agp <= shift_q[`CGW_AGP_DRV_BIT]; // R13
					rst_wdog_run_q <= shift_q[`CGW_RST_WD_BIT];
					rst_fc_en_q <= shift_q[`CGW_RST_FC_BIT];
					run_q <= shift_q[`CGW_RUN_BIT];
				end
				`CGW_OFS_SKEW: begin
					skew_o.cpu <= shift_q[`CGW_CPU_SKEW_HI:`CGW_CPU_SKEW_LO]; // R14
					skew_o.pci <= shift_q[`CGW_PCI_SKEW_HI:`CGW_PCI_SKEW_LO]; // R15
					skew_o.agp <= shift_q[`CGW_AGP_SKEW_HI:`CGW_AGP_SKEW_LO]; // R16
				end
				default: begin
				end
			endcase
		end
	end

	// time-out flag: expiry wins over a clearing write
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			flag_q <= 1'h0;
		end else if (expire) begin
			flag_q <= 1'h1; // R3
		end else if (wr_stb && cmd_q == `CGW_OFS_CTRL && shift_q[`CGW_FLAG_BIT]) begin
			flag_q <= 1'h0; // R6 R7
		end
	end

	// read data, reserved bits zero
	function automatic logic [7:0] read_byte(input logic [7:0] cmd);
		logic [7:0] r;
		r = 8'h00; // R19
		unique case (cmd)
			`CGW_OFS_TIMEOUT: begin
				r[`CGW_TO_HI:`CGW_TO_LO] = timeout_q;
				r[`CGW_PRESC_BIT] = presc_q;
			end
			`CGW_OFS_CTRL: begin
				r[`CGW_USB_DRV_BIT] = drive_o.usb;
				r[`CGW_PCI_CLK_DRIVE_HIGH_BIT] = drive_o.pci;
				r[`CGW_AGP_DRV_BIT] = drive_o.agp;
				r[`CGW_RST_WD_BIT] = rst_wdog_run_q;
				r[`CGW_RST_FC_BIT] = rst_fc_en_q;
				r[`CGW_FLAG_BIT] = flag_q; // R6
				r[`CGW_RUN_BIT] = run_q;
			end
			`CGW_OFS_SKEW: begin
				r[`CGW_CPU_SKEW_HI:`CGW_CPU_SKEW_LO] = skew_o.cpu;
				r[`CGW_PCI_SKEW_HI:`CGW_PCI_SKEW_LO] = skew_o.pci;
				r[`CGW_AGP_SKEW_HI:`CGW_AGP_SKEW_LO] = skew_o.agp;
			end
			default: begin
			end
		endcase
		return r;
	endfunction : read_byte

	// ========================================
	// smbus byte read and write slave
	cgw_pkg::cgw_smb_state_t smb_q;
	logic [3:0] bits_q;
	logic rnw_q;
	logic [7:0] rd_byte;

	always_comb begin
		rd_byte = read_byte(cmd_q);
	end

	assign wr_stb = (smb_q == cgw_pkg::SMB_WDATA) && scl_fall && (bits_q == 4'h8);

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			smb_q <= cgw_pkg::SMB_IDLE;
			bits_q <= 4'h0;
			rnw_q <= 1'h0;
			cmd_q <= 8'h00;
			shift_q <= 8'h00;
			smb_data_oe_o <= 1'h0;
			smb_data_o <= 1'h0;
		end else if (bus_start) begin
			smb_q <= cgw_pkg::SMB_ADDR;
			bits_q <= 4'h0;
			smb_data_oe_o <= 1'h0;
		end else if (bus_stop) begin
			smb_q <= cgw_pkg::SMB_IDLE;
			smb_data_oe_o <= 1'h0;
		end else if (scl_rise) begin
			unique case (smb_q)
				cgw_pkg::SMB_ADDR, cgw_pkg::SMB_CMD, cgw_pkg::SMB_WDATA: begin
					shift_q <= {shift_q[6:0], sda};
					bits_q <= bits_q + 4'h1;
				end
				cgw_pkg::SMB_RDATA: begin
					shift_q <= {shift_q[6:0], 1'h0};
					bits_q <= bits_q + 4'h1;
				end
				cgw_pkg::SMB_RDATA_ACK: begin
					smb_q <= cgw_pkg::SMB_IDLE;
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			unique case (smb_q)
				cgw_pkg::SMB_ADDR: begin
					if (bits_q == 4'h8) begin
						if (shift_q[7:1] == SMB_ADDR) begin
							smb_q <= cgw_pkg::SMB_ADDR_ACK;
							rnw_q <= shift_q[0];
							smb_data_oe_o <= 1'h1;
						end else begin
							smb_q <= cgw_pkg::SMB_IDLE;
						end
					end
				end
				cgw_pkg::SMB_ADDR_ACK: begin
					bits_q <= 4'h0;
					if (rnw_q) begin
						smb_q <= cgw_pkg::SMB_RDATA;
						shift_q <= rd_byte;
						smb_data_oe_o <= ~rd_byte[7];
					end else begin
						smb_q <= cgw_pkg::SMB_CMD;
						smb_data_oe_o <= 1'h0;
					end
				end
				cgw_pkg::SMB_CMD: begin
					if (bits_q == 4'h8) begin
						smb_q <= cgw_pkg::SMB_CMD_ACK;
						cmd_q <= shift_q;
						smb_data_oe_o <= 1'h1;
					end
				end
				cgw_pkg::SMB_CMD_ACK, cgw_pkg::SMB_WDATA_ACK: begin
					smb_q <= cgw_pkg::SMB_WDATA;
					bits_q <= 4'h0;
					smb_data_oe_o <= 1'h0;
				end
				cgw_pkg::SMB_WDATA: begin
					if (bits_q == 4'h8) begin
						smb_q <= cgw_pkg::SMB_WDATA_ACK;
						smb_data_oe_o <= 1'h1;
					end
				end
				cgw_pkg::SMB_RDATA: begin
					if (bits_q == 4'h8) begin
						smb_q <= cgw_pkg::SMB_RDATA_ACK;
						smb_data_oe_o <= 1'h0;
					end else begin
						smb_data_oe_o <= ~shift_q[7];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// writes to other command codes go to the frequency logic
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			ext_wr_o <= '0;
		end else begin
			ext_wr_o.valid <= wr_stb && !freq_lock_o && !expire && cmd_q != `CGW_OFS_TIMEOUT
				&& cmd_q != `CGW_OFS_CTRL && cmd_q != `CGW_OFS_SKEW; // R11
			ext_wr_o.cmd <= cmd_q;
			ext_wr_o.data <= shift_q;
		end
	end

	// ========================================
	// prescaler and watchdog
	cgw_pkg::cgw_wd_state_t wd_q;
	logic [4:0] cnt_q;
	logic [31:0] pre_q;
	logic tick;

	assign tick = pre_q == (presc_q ? LONG_TICK_CYC - 1 : SHORT_TICK_CYC - 1); // R2
	assign expire = (wd_q == cgw_pkg::WD_COUNT) && run_q && tick && cnt_q <= 5'h01; // R3

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			pre_q <= 32'h0;
		end else if (wd_q != cgw_pkg::WD_COUNT || tick) begin
			pre_q <= 32'h0;
		end else begin
			pre_q <= pre_q + 32'h1; // R18
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wd_q <= cgw_pkg::WD_OFF;
			cnt_q <= `CGW_TO_RST;
		end else if (!run_q) begin
			wd_q <= cgw_pkg::WD_OFF; // R12
			cnt_q <= timeout_q; // R8
		end else begin
			unique case (wd_q)
				cgw_pkg::WD_OFF: begin
					wd_q <= cgw_pkg::WD_ARMED;
				end
				cgw_pkg::WD_ARMED: begin
					cnt_q <= timeout_q;
					if (freq_change_i) begin
						wd_q <= cgw_pkg::WD_COUNT; // R9
					end
				end
				cgw_pkg::WD_COUNT: begin
					if (expire) begin
						wd_q <= cgw_pkg::WD_LOCKED; // R10
					end else if (tick) begin
						cnt_q <= cnt_q - 5'h01; // R18
					end
				end
				cgw_pkg::WD_LOCKED: begin
				end
			endcase
		end
	end

	// ========================================
	// lock, recovery and reset pulse
	logic [7:0] rst_cnt_q;
	logic [1:0] fs_wait_q;

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			freq_lock_o <= 1'h0;
			recovery_load_o <= 1'h0;
			recovery_from_prog_o <= 1'h0;
		end else begin
			freq_lock_o <= run_q && (expire || wd_q == cgw_pkg::WD_LOCKED); // R10 R12
			recovery_load_o <= expire; // R10
			if (expire) begin
				recovery_from_prog_o <= recovery_source_sel_i; // R17
			end
		end
	end

	// straps latched once the synchroniser has filled
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			recovery_fs_o <= 5'h00;
			fs_wait_q <= 2'h0;
		end else if (fs_wait_q != `CGW_FS_SETTLE) begin
			recovery_fs_o <= fs_sync_q; // R17
			fs_wait_q <= fs_wait_q + 2'h1;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			rst_cnt_q <= 8'h00;
			sys_reset_o <= 1'h0;
		end else if ((expire && rst_wdog_run_q)
			|| (freq_change_i && rst_fc_en_q && !freq_lock_o)) begin
			rst_cnt_q <= `CGW_RST_PULSE_CYC; // R3 R4 R5 R18
			sys_reset_o <= 1'h1;
		end else if (rst_cnt_q != 8'h00) begin
			rst_cnt_q <= rst_cnt_q - 8'h01;
			sys_reset_o <= rst_cnt_q != 8'h01;
		end
	end
endmodule : cgw_watchdog_ctrl

// file: dv/cgw_checker.sv
// assertions on the control block ports
`timescale 1ns/1ps
module cgw_checker (
	// clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// watched ports
	input wire logic recovery_source_sel_i,
	input wire logic smb_data_o,
	input wire cgw_pkg::cgw_ext_wr_t ext_wr_o,
	input wire logic freq_lock_o,
	input wire logic recovery_load_o,
	input wire logic recovery_from_prog_o,
	input wire logic sys_reset_o
);
	logic [7:0] len_q;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	// ========================================
	// reset pulse length
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			len_q <= 8'h00;
		end else begin
			len_q <= sys_reset_o ? len_q + 8'h01 : 8'h00;
		end
	end
	sequence expire_s;
		$rose(freq_lock_o) ##0 recovery_load_o;
	endsequence
	// ========================================
	// properties
	drain_low_a: assert property (smb_data_o == 1'b0) else $error("data out high");
	pulse_width_a: assert property ($fell(sys_reset_o) |-> len_q == 8'h64)
		else $error("reset pulse width");
	pulse_bound_a: assert property (len_q <= 8'h64) else $error("reset pulse long");
	lock_entry_a: assert property ($rose(freq_lock_o) |-> recovery_load_o)
		else $error("lock without load");
	lock_hold_a: assert property (expire_s |=> freq_lock_o [*8])
		else $error("lock dropped");
	lock_block_a: assert property (freq_lock_o |-> !ext_wr_o.valid)
		else $error("write while locked");
	wr_pulse_a: assert property (ext_wr_o.valid |=> !ext_wr_o.valid)
		else $error("write pulse long");
	recov_src_a: assert property (recovery_load_o |->
		recovery_from_prog_o == $past(recovery_source_sel_i)) else $error("recovery source");
endmodule : cgw_checker

// file: dv/cgw_smb_host.sv
// smbus host model driving the control block pins
`timescale 1ns/1ps
module cgw_smb_host #(
	parameter logic [6:0] ADDR = 7'h50
) (
	// bus pins
	input wire logic sda_i,
	output logic scl_o,
	output logic low_o
);
	// ========================================
	// bit level, clock stands high when idle
	initial begin
		scl_o = 1'b1;
		low_o = 1'b0;
	end
	task automatic bx(input logic b, output logic r);
		#80 low_o = !b;
		#20 scl_o = 1'b1;
		#30 r = sda_i;
		#30 scl_o = 1'b0;
	endtask : bx
	task automatic by(input logic [7:0] d, output logic [7:0] r, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bx(d[i], r[i]);
		end
		bx(1'b1, a);
	endtask : by
	task automatic st();
		#83 low_o = 1'b0;
		#20 scl_o = 1'b1;
		#30 low_o = 1'b1;
		#30 scl_o = 1'b0;
	endtask : st
	task automatic sp();
		#80 low_o = 1'b1;
		#20 scl_o = 1'b1;
		#30 low_o = 1'b0;
		#30;
	endtask : sp
	// ========================================
	// byte write and byte read
	task automatic wr(input logic [7:0] c, input logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2;
		st();
		by({ADDR, 1'b0}, r, a0);
		by(c, r, a1);
		by(d, r, a2);
		sp();
		ok = !(a0 | a1 | a2);
	endtask : wr
	task automatic rd(input logic [7:0] c, output logic [7:0] d, output logic ok);
		logic [7:0] r;
		logic a0, a1, a2, n;
		st();
		by({ADDR, 1'b0}, r, a0);
		by(c, r, a1);
		st();
		by({ADDR, 1'b1}, r, a2);
		by(8'hff, d, n);
		sp();
		ok = !(a0 | a1 | a2);
	endtask : rd
endmodule : cgw_smb_host

// file: dv/cgw_watchdog_ctrl_tb.sv
// self-checking bench for the watchdog and tuning control block
`timescale 1ns/1ps
module cgw_watchdog_ctrl_tb;
	logic clock_i, rst_i, scl, low, sda, freq_change_i, recovery_source_sel_i;
	logic smb_data_o, smb_data_oe_o, freq_lock_o, recovery_load_o, recovery_from_prog_o;
	logic sys_reset_o, rprev;
	logic [4:0] recovery_fs_o;
	logic [7:0] rd;
	cgw_pkg::cgw_ext_wr_t ext_wr_o, last_wr;
	cgw_pkg::cgw_drive_t drive_o;
	cgw_pkg::cgw_skew_t skew_o;
	int miscompares = 0;
	int total_checks = 0;
	int n_wr = 0;
	int n_rst = 0;
	int n;
	assign sda = (smb_data_oe_o ? smb_data_o : 1'b1) & !low;
	cgw_watchdog_ctrl #(.SHORT_TICK_CYC(20), .LONG_TICK_CYC(40), .SMB_ADDR(7'h50))
	cgw_watchdog_ctrl_i (.clock_i(clock_i), .rst_i(rst_i), .smb_clk_i(scl), .smb_data_i(sda),
		.smb_data_o(smb_data_o), .smb_data_oe_o(smb_data_oe_o), .freq_change_i(freq_change_i),
		.recovery_source_sel_i(recovery_source_sel_i), .fs_strap_i(5'h15),
		.ext_wr_o(ext_wr_o), .freq_lock_o(freq_lock_o), .recovery_load_o(recovery_load_o),
		.recovery_from_prog_o(recovery_from_prog_o), .recovery_fs_o(recovery_fs_o),
		.sys_reset_o(sys_reset_o), .drive_o(drive_o), .skew_o(skew_o));
	cgw_smb_host #(.ADDR(7'h50)) cgw_smb_host_i (.sda_i(sda), .scl_o(scl), .low_o(low));
	// ========================================
	// clock, monitor, watchdog
	initial begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end
	always @(posedge clock_i) begin
		rprev <= sys_reset_o;
		if (sys_reset_o && !rprev) n_rst++;
		if (ext_wr_o.valid) begin
			n_wr++;
			last_wr <= ext_wr_o;
		end
	end
	initial begin
		#1000000;
		miscompares++;
		results();
	end
	// ========================================
	// tasks
	task automatic check(input logic [16:0] seen, input logic [16:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		logic ok;
		@(negedge clock_i);
		cgw_smb_host_i.wr(c, d, ok);
		check({16'h0000, ok}, 17'h00001);
	endtask : wr
	task automatic rdc(input logic [7:0] c, input logic [7:0] e);
		logic ok;
		@(negedge clock_i);
		cgw_smb_host_i.rd(c, rd, ok);
		check({8'h00, ok, rd}, {8'h01, e});
	endtask : rdc
	task automatic fc();
		@(posedge clock_i);
		freq_change_i <= 1'b1;
		@(posedge clock_i);
		freq_change_i <= 1'b0;
	endtask : fc
	task automatic wait_load();
		n = 0;
		while (recovery_load_o !== 1'b1 && n < 2000) begin
			@(negedge clock_i);
			n++;
		end
	endtask : wait_load
	task automatic idle(input int c);
		repeat (c) @(negedge clock_i);
	endtask : idle
	task automatic results();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results
	// ========================================
	// tests
	initial begin
		rst_i = 1'b1;
		freq_change_i = 1'b0;
		recovery_source_sel_i = 1'b0;
		repeat (12) @(posedge clock_i);
		rst_i <= 1'b0;
		idle(4);
		check(recovery_fs_o, 5'h15);
		check({drive_o, skew_o}, 10'h000);
		rdc(8'h08, 8'h3e);
		rdc(8'h09, 8'h00);
		rdc(8'h0a, 8'h00);
		wr(8'h08, 8'hff);
		rdc(8'h08, 8'h3f);
		wr(8'h09, 8'he1);
		rdc(8'h09, 8'he0);
		check(drive_o, 3'h7);
		for (int i = 0; i < 8; i++) begin
			wr(8'h0a, {i[2:0], 1'b1, i[1:0], i[1:0]});
			check(skew_o, {i[2:0], i[1:0], i[1:0]});
		end
		rdc(8'h0a, 8'hef);
		wr(8'h20, 8'h5a);
		check(last_wr, {1'b1, 8'h20, 8'h5a});
		rdc(8'h20, 8'h00);
		$display("test registers done");
		wr(8'h08, 8'h06);
		wr(8'h09, 8'h12);
		check(drive_o, 3'h0);
		idle(200);
		check(freq_lock_o, 1'b0);
		fc();
		wait_load();
		check({16'h0000, n >= 60 && n <= 63}, 17'h00001);
		idle(1);
		check({freq_lock_o, recovery_from_prog_o}, 2'h2);
		rdc(8'h09, 8'h16);
		check(n_rst[16:0], 17'h00001);
		wr(8'h21, 8'h33);
		check(n_wr[16:0], 17'h00001);
		wr(8'h09, 8'h12);
		rdc(8'h09, 8'h16);
		wr(8'h09, 8'h16);
		rdc(8'h09, 8'h12);
		check(freq_lock_o, 1'b1);
		wr(8'h09, 8'h00);
		check(freq_lock_o, 1'b0);
		wr(8'h21, 8'h33);
		check(n_wr[16:0], 17'h00002);
		$display("test expiry done");
		wr(8'h09, 8'h08);
		fc();
		idle(120);
		check(n_rst[16:0], 17'h00002);
		wr(8'h09, 8'h00);
		fc();
		idle(120);
		check(n_rst[16:0], 17'h00002);
		wr(8'h08, 8'h3e);
		wr(8'h09, 8'h02);
		fc();
		wr(8'h09, 8'h00);
		wr(8'h08, 8'h03);
		idle(500);
		check(freq_lock_o, 1'b0);
		wr(8'h09, 8'h02);
		@(posedge clock_i) recovery_source_sel_i <= 1'b1;
		fc();
		wait_load();
		check({16'h0000, n >= 40 && n <= 43}, 17'h00001);
		idle(120);
		check({n_rst[15:0], recovery_from_prog_o}, 17'h00005);
		rdc(8'h09, 8'h06);
		$display("test resets done");
		results();
	end
endmodule : cgw_watchdog_ctrl_tb

bind cgw_watchdog_ctrl cgw_checker cgw_checker_i (.clock_i(clock_i), .rst_i(rst_i),
	.recovery_source_sel_i(recovery_source_sel_i), .smb_data_o(smb_data_o),
	.ext_wr_o(ext_wr_o), .freq_lock_o(freq_lock_o), .recovery_load_o(recovery_load_o),
	.recovery_from_prog_o(recovery_from_prog_o), .sys_reset_o(sys_reset_o));
